// file: hw/eipm_map.svh
// Purpose: constants for the emulator i/o port mapper
// Assumes: 16-bit port address, 16-bit data path
// Notes: block index is the upper port address bits
// Behaviour
// - Every processor bus cycle is passed on to the target regardless of mapping.
// - A write to an emulator-mapped location goes both to the emulator resource and to the target.
// - A read of an emulator-mapped location runs on both sides but returns the emulator's data.
// - The port space holds 64K byte ports or 32K word ports, each steerable by the map.
// - The map holds one steering bit per 64-byte block of ports.
// - A partition that ends off a block boundary is extended up to the next boundary.
// - After initialisation all 10000H ports are steered to the target.
// - Each block is either target-served or emulator-handled, and target ports are completed by the target.
// - A read of an emulator-handled port raises an input request and returns the handler's value.
// - Each handler access reports the port number and a flag that is true for a read.
// - Each handler access carries a flag that is true for a byte access.
// - A write to an emulator-handled port passes the written value to the handler.
`ifndef EIPM_MAP_SVH
`define EIPM_MAP_SVH
`define EIPM_ADDR_W 16
`define EIPM_DATA_W 16
`define EIPM_BLK_SHIFT 6
`define EIPM_NBLK 1024
`define EIPM_BLK_W 10
`define EIPM_MAP_RESET 1'b0
`define EIPM_PORT_SPAN 17'h10000
`endif

// file: hw/eipm_pkg.sv
// Purpose: types for the emulator i/o port mapper
// Assumes: eipm_map.svh holds the numbers
// Notes: none
`include "eipm_map.svh"
package eipm_pkg;
  typedef enum logic [2:0] {
    CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR, CYC_INTA, CYC_HALT
  } eipm_cyc_e;

  typedef enum {ST_IDLE, ST_TGT, ST_HOST} eipm_state_e;

  typedef struct packed {
    logic [`EIPM_ADDR_W-1:0] port;
    logic is_read;
    logic is_byte;
    logic [`EIPM_DATA_W-1:0] value;
  } eipm_host_req_s;

  typedef struct packed {
    logic start;
    logic [`EIPM_ADDR_W-1:0] first;
    logic [`EIPM_ADDR_W:0] length;
    logic to_emulator;
  } eipm_map_cmd_s;
endpackage

// file: hw/eipm_port_mapper.sv
// Purpose: steer processor port cycles to target or emulator handler
// Assumes: mem_emul comes from the memory map logic; cycles arrive one at a time
// Notes: map commands are applied one block per clock; a command in progress stalls cycles
`timescale 1ns/10ps
`default_nettype none
`include "eipm_map.svh"
module eipm_port_mapper
  import eipm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cpu_req,
  input wire eipm_cyc_e cpu_cyc,
  input wire logic [`EIPM_ADDR_W-1:0] cpu_addr,
  input wire logic cpu_byte,
  input wire logic [`EIPM_DATA_W-1:0] cpu_wdata,
  input wire logic mem_emul,
  input wire logic [`EIPM_DATA_W-1:0] mem_rdata,
  output logic cpu_done,
  output logic [`EIPM_DATA_W-1:0] cpu_rdata,
  output logic tgt_strobe,
  output eipm_cyc_e tgt_cyc,
  output logic [`EIPM_ADDR_W-1:0] tgt_addr,
  output logic tgt_byte,
  output logic [`EIPM_DATA_W-1:0] tgt_wdata,
  input wire logic tgt_ready_pin,
  input wire logic [`EIPM_DATA_W-1:0] tgt_rdata_pin,
  output logic host_valid,
  output eipm_host_req_s host_req,
  input wire logic host_ack,
  input wire logic [`EIPM_DATA_W-1:0] port_value,
  input wire eipm_map_cmd_s port_map_command,
  output logic map_busy
);
  typedef struct packed {
    eipm_state_e st;
    logic [`EIPM_NBLK-1:0] emu;
    logic map_act;
    logic [`EIPM_BLK_W-1:0] map_blk;
    logic [`EIPM_BLK_W:0] map_left;
    logic map_val;
    logic emu_cyc;
    logic host_pend;
    logic tgt_seen;
    logic [1:0] rdy_s;
    logic [`EIPM_DATA_W-1:0] dat_s1, dat_s2;
    logic cpu_done;
    logic [`EIPM_DATA_W-1:0] cpu_rdata;
    logic tgt_strobe;
    eipm_cyc_e tgt_cyc;
    logic [`EIPM_ADDR_W-1:0] tgt_addr;
    logic tgt_byte;
    logic [`EIPM_DATA_W-1:0] tgt_wdata;
    logic host_valid;
    eipm_host_req_s host_req;
    logic [`EIPM_DATA_W-1:0] host_data;
  } eipm_state_s;

  eipm_state_s s_q, s_d;

  function automatic logic [`EIPM_BLK_W-1:0] blk_of(input logic [`EIPM_ADDR_W-1:0] a);
    blk_of = a[`EIPM_ADDR_W-1:`EIPM_BLK_SHIFT];
  endfunction

  // blocks touched by a partition, rounded up past any partial end block
  function automatic logic [`EIPM_BLK_W:0] blk_count(input logic [`EIPM_ADDR_W-1:0] first,
                                                    input logic [`EIPM_ADDR_W:0] len);
    logic [`EIPM_ADDR_W+1:0] last_ex;
    logic [`EIPM_ADDR_W+1:0] span;
    last_ex = {2'b00, first} + {1'b0, len};
    if (last_ex > {1'b0, `EIPM_PORT_SPAN}) begin
      last_ex = {1'b0, `EIPM_PORT_SPAN};
    end
    span = last_ex - {2'b00, first[`EIPM_ADDR_W-1:`EIPM_BLK_SHIFT], 6'h00} + 18'h0003f;
    blk_count = span[`EIPM_ADDR_W:`EIPM_BLK_SHIFT];
  endfunction

  // cycle kinds are decoded in several places, so each has one definition
  function automatic logic is_io_cyc(input eipm_cyc_e c);
    is_io_cyc = (c == CYC_IO_RD) || (c == CYC_IO_WR);
  endfunction

  function automatic logic is_mem_cyc(input eipm_cyc_e c);
    is_mem_cyc = (c == CYC_MEM_RD) || (c == CYC_MEM_WR);
  endfunction

  function automatic logic is_port_rd(input eipm_cyc_e c);
    is_port_rd = (c == CYC_IO_RD);
  endfunction

  // the handler may answer while the target is still busy or after it
  function automatic eipm_state_s take_answer(input eipm_state_s s, input logic ack,
                                              input logic [`EIPM_DATA_W-1:0] val);
    take_answer = s;
    if (s.host_valid && ack) begin
      take_answer.host_valid = 1'b0;
      take_answer.host_pend = 1'b0;
      take_answer.host_data = val;
    end
  endfunction

  // mapped reads take the emulator side and drop whatever the target drove
  function automatic logic [`EIPM_DATA_W-1:0] pick_rdata(input logic emu, input eipm_cyc_e c,
                                                         input logic [`EIPM_DATA_W-1:0] host,
                                                         input logic [`EIPM_DATA_W-1:0] mem,
                                                         input logic [`EIPM_DATA_W-1:0] tgt);
    if (!emu) begin
      pick_rdata = tgt;
    end else if (is_port_rd(c)) begin
      pick_rdata = host;
    end else begin
      pick_rdata = mem;
    end
  endfunction

  logic io_cyc;
  logic blk_emu;

  always_comb begin
    s_d = s_q;
    s_d.cpu_done = 1'b0;
    s_d.tgt_strobe = 1'b0;
    // pin inputs pass two flops before use
    s_d.rdy_s = {s_q.rdy_s[0], tgt_ready_pin};
    s_d.dat_s1 = tgt_rdata_pin;
    s_d.dat_s2 = s_q.dat_s1;
    io_cyc = is_io_cyc(cpu_cyc);
    blk_emu = s_q.emu[blk_of(cpu_addr)];

    // map updates run one block per clock so a full-range command takes 1024 cycles
    if (s_q.map_act) begin
      s_d.emu[s_q.map_blk] = s_q.map_val;
      s_d.map_blk = s_q.map_blk + 10'h001;
      s_d.map_left = s_q.map_left - 11'h001;
      if (s_q.map_left == 11'h001) begin
        s_d.map_act = 1'b0;
      end
    end else if (port_map_command.start && s_q.st == ST_IDLE) begin
      s_d.map_blk = blk_of(port_map_command.first);
      s_d.map_left = blk_count(port_map_command.first, port_map_command.length);
      s_d.map_val = port_map_command.to_emulator;
      s_d.map_act = (s_d.map_left != 11'h000);
    end

    unique case (s_q.st)
      ST_IDLE: begin
        if (cpu_req && !s_q.map_act && !port_map_command.start) begin
          // every cycle kind goes to the target, mapped or not
          s_d.tgt_strobe = 1'b1;
          s_d.tgt_cyc = cpu_cyc;
          s_d.tgt_addr = cpu_addr;
          s_d.tgt_byte = cpu_byte;
          s_d.tgt_wdata = cpu_wdata;
          s_d.tgt_seen = 1'b0;
          s_d.emu_cyc = io_cyc ? blk_emu : (is_mem_cyc(cpu_cyc) && mem_emul);
          s_d.host_pend = io_cyc && blk_emu;
          if (io_cyc && blk_emu) begin
            s_d.host_valid = 1'b1;
            s_d.host_req.port = cpu_addr;
            s_d.host_req.is_read = is_port_rd(cpu_cyc);
            s_d.host_req.is_byte = cpu_byte;
            s_d.host_req.value = cpu_wdata;
          end
          s_d.st = ST_TGT;
        end
      end
      ST_TGT: begin
        s_d = take_answer(s_d, host_ack, port_value);
        // halt never gets ready from the target, so it ends on its own
        if (s_q.tgt_cyc == CYC_HALT || s_q.rdy_s[1]) begin
          s_d.tgt_seen = 1'b1;
        end
        if (s_d.tgt_seen) begin
          s_d.st = ST_HOST;
        end
      end
      ST_HOST: begin
        s_d = take_answer(s_d, host_ack, port_value);
        // the cycle stays pending until the handler answers
        if (!s_d.host_pend) begin
          s_d.cpu_done = 1'b1;
          s_d.cpu_rdata = pick_rdata(s_q.emu_cyc, s_q.tgt_cyc, s_d.host_data, mem_rdata, s_q.dat_s2);
          s_d.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.emu <= {`EIPM_NBLK{`EIPM_MAP_RESET}};
      s_q.tgt_cyc <= CYC_MEM_RD;
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_done = s_q.cpu_done;
  assign cpu_rdata = s_q.cpu_rdata;
  assign tgt_strobe = s_q.tgt_strobe;
  assign tgt_cyc = s_q.tgt_cyc;
  assign tgt_addr = s_q.tgt_addr;
  assign tgt_byte = s_q.tgt_byte;
  assign tgt_wdata = s_q.tgt_wdata;
  assign host_valid = s_q.host_valid;
  assign host_req = s_q.host_req;
  assign map_busy = s_q.map_act;
endmodule
`default_nettype wire

// file: tb/eipm_port_mapper_props.sv
// Purpose: port-level checks of the emulator i/o port mapper
// Assumes: cycles taken only from idle; bench never starts a map with a cycle pending
// Notes: map bound allows all 1024 blocks plus margin
`timescale 1ns/10ps
`default_nettype none
module eipm_port_mapper_props
  import eipm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cpu_req,
  input wire eipm_cyc_e cpu_cyc,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_byte,
  input wire logic [15:0] cpu_wdata,
  input wire logic cpu_done,
  input wire logic tgt_strobe,
  input wire eipm_cyc_e tgt_cyc,
  input wire logic [15:0] tgt_addr,
  input wire logic tgt_byte,
  input wire logic host_valid,
  input wire eipm_host_req_s host_req,
  input wire logic host_ack,
  input wire logic map_busy
);
  // cycles that map_busy has stood, kept here so that a long map needs no wide delay range
  logic [10:0] map_cnt_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      map_cnt_q <= 11'h000;
    end else if (map_busy) begin
      map_cnt_q <= map_cnt_q + 11'h001;
    end else begin
      map_cnt_q <= 11'h000;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_strobe_copies: assert property (tgt_strobe |-> tgt_cyc == $past(cpu_cyc) && tgt_addr == $past(cpu_addr)
    && tgt_byte == $past(cpu_byte)) else $error("target cycle differs from request");
  chk_take_launches: assert property ($rose(cpu_req) && !map_busy |=> tgt_strobe)
    else $error("request not launched on target");
  chk_strobe_pulse: assert property (tgt_strobe |=> !tgt_strobe) else $error("strobe too long");
  chk_host_fields: assert property ($rose(host_valid) |-> host_req.port == tgt_addr
    && host_req.is_read == (tgt_cyc == CYC_IO_RD) && host_req.is_byte == tgt_byte) else $error("handler fields wrong");
  chk_host_value: assert property ($rose(host_valid) && !host_req.is_read |-> host_req.value == $past(cpu_wdata))
    else $error("handler write value wrong");
  chk_host_hold: assert property (host_valid && !host_ack |=> host_valid) else $error("handler request dropped");
  chk_no_early_done: assert property (host_valid |-> !cpu_done) else $error("done before handler");
  chk_host_io_only: assert property (host_valid |-> tgt_cyc inside {CYC_IO_RD, CYC_IO_WR})
    else $error("handler used for non-port cycle");
  chk_map_bounded: assert property (map_busy |-> map_cnt_q <= 11'h400) else $error("map update hangs");
endmodule
bind eipm_port_mapper eipm_port_mapper_props u_props (.clk_sys, .rst_n, .cpu_req, .cpu_cyc, .cpu_addr, .cpu_byte,
  .cpu_wdata, .cpu_done, .tgt_strobe, .tgt_cyc, .tgt_addr, .tgt_byte, .host_valid, .host_req, .host_ack, .map_busy);
`default_nettype wire

// file: tb/eipm_tgt_model.sv
// Purpose: prototype target answering port and memory cycles
// Assumes: one cycle at a time
// Notes: ready delay varies with address; data inverted once released
`timescale 1ns/10ps
`default_nettype none
module eipm_tgt_model
  import eipm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic tgt_strobe,
  input wire eipm_cyc_e tgt_cyc,
  input wire logic [15:0] tgt_addr,
  output logic tgt_ready_pin,
  output logic [15:0] tgt_rdata_pin
);
  initial begin
    tgt_ready_pin = 1'b0;
    tgt_rdata_pin = 16'h0000;
    forever begin
      @(posedge clk_sys);
      // halt gets no ready, every other cycle does
      if (tgt_strobe === 1'b1 && tgt_cyc != CYC_HALT) begin
        repeat (int'(tgt_addr[1:0]) + 1) @(posedge clk_sys);
        tgt_ready_pin <= 1'b1;
        tgt_rdata_pin <= tgt_addr ^ 16'ha5a5;
        repeat (3) @(posedge clk_sys);
        tgt_ready_pin <= 1'b0;
        repeat (2) @(posedge clk_sys);
        // stale data must not look valid
        tgt_rdata_pin <= ~tgt_rdata_pin;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/eipm_port_mapper_tb_top.sv
// Purpose: directed bench for the port mapper
// Assumes: handler answers in the same cycle its request first shows
// Notes: none
`timescale 1ns/10ps
`default_nettype none
module eipm_port_mapper_tb_top
  import eipm_pkg::*;
;
  logic clk_sys, rst_n, cpu_req, cpu_byte, mem_emul, host_ack, cpu_done, tgt_strobe, tgt_byte, tgt_ready_pin;
  logic host_valid, map_busy;
  eipm_cyc_e cpu_cyc, tgt_cyc;
  logic [15:0] cpu_addr, cpu_wdata, mem_rdata, port_value, cpu_rdata, tgt_addr, tgt_wdata, tgt_rdata_pin;
  eipm_host_req_s host_req;
  eipm_map_cmd_s port_map_command;
  int err_total = 0;
  int n_checks = 0;
  eipm_port_mapper uut (.clk_sys, .rst_n, .cpu_req, .cpu_cyc, .cpu_addr, .cpu_byte, .cpu_wdata, .mem_emul,
    .mem_rdata, .cpu_done, .cpu_rdata, .tgt_strobe, .tgt_cyc, .tgt_addr, .tgt_byte, .tgt_wdata, .tgt_ready_pin,
    .tgt_rdata_pin, .host_valid, .host_req, .host_ack, .port_value, .port_map_command, .map_busy);
  eipm_tgt_model u_tgt (.clk_sys, .tgt_strobe, .tgt_cyc, .tgt_addr, .tgt_ready_pin, .tgt_rdata_pin);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input eipm_cyc_e k, input logic [15:0] a, input logic b, input logic emu, input logic hx);
    logic s, h;
    logic [15:0] e;
    eipm_host_req_s hr;
    e = hx ? a + 16'h1111 : (emu ? ~a : a ^ 16'ha5a5);
    s = 1'b0;
    h = 1'b0;
    hr = '0;
    @(posedge clk_sys) #1;
    cpu_req = 1'b1;
    cpu_cyc = k;
    cpu_addr = a;
    cpu_byte = b;
    cpu_wdata = a ^ 16'h0f0f;
    mem_emul = emu;
    mem_rdata = ~a;
    port_value = a + 16'h1111;
    for (int n = 0; n < 80 && cpu_done !== 1'b1; n++) begin
      @(posedge clk_sys) #1;
      host_ack = 1'b0;
      if (tgt_strobe === 1'b1) s = 1'b1;
      if (host_valid === 1'b1 && !h) begin
        h = 1'b1;
        hr = host_req;
        host_ack = 1'b1;
      end
    end
    cpu_req = 1'b0;
    chk(cpu_done, 1'b1);
    chk(s, 1'b1);
    chk(h, hx);
    if (k == CYC_IO_RD || k == CYC_MEM_RD || k == CYC_INTA) chk(cpu_rdata, e);
    if (k == CYC_IO_WR) chk(tgt_wdata, a ^ 16'h0f0f);
    if (hx) chk(hr.port, a);
    if (hx) chk(hr.is_read, k == CYC_IO_RD);
    if (hx) chk(hr.is_byte, b);
    if (hx && k == CYC_IO_WR) chk(hr.value, a ^ 16'h0f0f);
  endtask
  task automatic map(input logic [15:0] f, input logic [16:0] l, input logic e);
    @(posedge clk_sys) #1 port_map_command = '{1'b1, f, l, e};
    @(posedge clk_sys) #1 port_map_command.start = 1'b0;
    for (int n = 0; n < 1100 && map_busy === 1'b1; n++) @(posedge clk_sys) #1;
  endtask
  task automatic t_blocks();
    cyc(CYC_IO_RD, 16'h0002, 1'b0, 1'b0, 1'b0);
    map(16'h0000, 17'h00001, 1'b1);
    cyc(CYC_IO_RD, 16'h003f, 1'b1, 1'b0, 1'b1);
    cyc(CYC_IO_RD, 16'h0040, 1'b0, 1'b0, 1'b0);
    cyc(CYC_IO_WR, 16'h0002, 1'b0, 1'b0, 1'b1);
    $display("TB: blocks done");
  endtask
  task automatic t_other();
    cyc(CYC_MEM_RD, 16'h1234, 1'b0, 1'b1, 1'b0);
    cyc(CYC_MEM_RD, 16'h0102, 1'b0, 1'b0, 1'b0);
    cyc(CYC_MEM_WR, 16'h0003, 1'b0, 1'b1, 1'b0);
    cyc(CYC_INTA, 16'h0001, 1'b1, 1'b0, 1'b0);
    cyc(CYC_HALT, 16'h0000, 1'b0, 1'b0, 1'b0);
    map(16'hffc1, 17'h00001, 1'b1);
    cyc(CYC_IO_RD, 16'hffff, 1'b1, 1'b0, 1'b1);
    map(16'h0000, 17'h10000, 1'b0);
    cyc(CYC_IO_RD, 16'hffff, 1'b1, 1'b0, 1'b0);
    cyc(CYC_IO_WR, 16'h003e, 1'b0, 1'b0, 1'b0);
    $display("TB: other cycles done");
  endtask
  task automatic test_done();
    $display("TB: checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'b0; cpu_req = 1'b0; cpu_cyc = CYC_MEM_RD; cpu_addr = 16'h0000; cpu_byte = 1'b0;
    cpu_wdata = 16'h0000; mem_emul = 1'b0; mem_rdata = 16'h0000; host_ack = 1'b0; port_value = 16'h0000;
    port_map_command = '0;
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_blocks();
    t_other();
    test_done();
  end
  // whole run is just over a thousand cycles
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
